// *** common/irq_doze_pkg.sv ***
// Package: register map, field layout and types of the flag bank and throttle block
package irq_doze_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_GLOBAL   = 8'h00;
    localparam logic [7:0] OFF_FLAGS6   = 8'h04;
    localparam logic [7:0] OFF_FLAGS7   = 8'h08;
    localparam logic [7:0] OFF_ENABLE6  = 8'h0c;
    localparam logic [7:0] OFF_ENABLE7  = 8'h10;
    localparam logic [7:0] OFF_THROTTLE = 8'h14;
    localparam logic [7:0] OFF_STATUS   = 8'h18;
    localparam logic [7:0] OFF_MASK     = 8'h1c;

    // ------------------------------------------------------------------
    // Field positions and implemented-bit masks
    // ------------------------------------------------------------------
    localparam int GIE_BIT   = 7;
    localparam int PERIPHERAL_INTERRUPT_ENABLE_BIT  = 6;
    localparam int EDGE_BIT  = 0;
    localparam logic [7:0] GLOBAL_MASK = 8'hc1;
    localparam int CAP1_BIT  = 0;
    localparam int CAP2_BIT  = 1;
    localparam logic [7:0] FLAGS6_MASK = 8'h03;
    localparam int NVM_BIT   = 5;
    localparam int NCO_BIT   = 4;
    localparam int WAVE_BIT  = 0;
    localparam logic [7:0] FLAGS7_MASK = 8'h31;
    // Throttle control: ratio [2:0], enable 6, recover 5, on-exit 4
    localparam int RATIO_LSB = 0;
    localparam int TEN_BIT   = 6;
    localparam int ROI_BIT   = 5;
    localparam int TOE_BIT   = 4;
    localparam logic [7:0] THROTTLE_MASK = 8'h77;
    // Event status: 0 entry, 1 return, 2 new pending request
    localparam logic [7:0] STATUS_MASK = 8'h07;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] FLAGS_RESET   = 8'h00;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam logic [7:0] THROTTLE_RESET = 8'h00;

    // Capture/compare unit mode
    typedef enum logic [1:0] {
        CAPCMP_CAPTURE = 2'h0,
        CAPCMP_COMPARE = 2'h1,
        CAPCMP_PWM     = 2'h2
    } capcmp_mode_type;

    // Per-unit event strobes
    typedef struct packed {
        logic capture;
        logic compare_match;
        logic trailing_edge;
    } capcmp_event_type;

    // Core handshake
    typedef struct packed {
        logic isr_entry;
        logic isr_return;
    } core_event_type;

endpackage : irq_doze_pkg

// *** src/irq_doze.sv ***
// Interrupt flag bank with enables and CPU throttle (doze) control, APB slave
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ns

module irq_doze
    import irq_doze_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    input  wire capcmp_mode_type     capcmp_mode_select [2],
    input  wire capcmp_event_type    capcmp_event [2],
    input  wire logic                nvm_done,
    input  wire logic                nco_rollover,
    input  wire logic                cwg_shutdown,
    input  wire core_event_type      core_event,
    output logic                     cpu_irq_request,
    output logic                     wake_request,
    output logic                     cpu_clock_enable,
    output logic                     periph_clock_enable,
    output logic                     external_edge_select,
    output logic                     irq
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] global_r, flags6_r, flags7_r, enable6_r, enable7_r;
    logic [7:0] throttle_r, status_r, mask_r;
    logic [7:0] throttle_nxt;
    logic [7:0] doze_cnt_r;
    logic       pending_d_r;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Writes land only at the first access edge; a repeat would erase a flag set meanwhile
    wire        wr_en   = psel & penable & pwrite & ~pready;
    wire        rd_en   = psel & penable & ~pwrite;
    wire        hit_glb = (paddr == OFF_GLOBAL);
    wire        hit_f6  = (paddr == OFF_FLAGS6);
    wire        hit_f7  = (paddr == OFF_FLAGS7);
    wire        hit_e6  = (paddr == OFF_ENABLE6);
    wire        hit_e7  = (paddr == OFF_ENABLE7);
    wire        hit_thr = (paddr == OFF_THROTTLE);
    wire        hit_st  = (paddr == OFF_STATUS);
    wire        hit_msk = (paddr == OFF_MASK);
    wire        mapped  = hit_glb | hit_f6 | hit_f7 | hit_e6 | hit_e7 | hit_thr | hit_st | hit_msk;
    wire  [7:0] wbyte   = pwdata[7:0];
    logic [7:0] rd_mux;

    always_comb begin
        if (hit_glb) rd_mux = global_r;
        else if (hit_f6) rd_mux = flags6_r;
        else if (hit_f7) rd_mux = flags7_r;
        else if (hit_e6) rd_mux = enable6_r;
        else if (hit_e7) rd_mux = enable7_r;
        else if (hit_thr) rd_mux = throttle_r;
        else if (hit_st) rd_mux = status_r;
        else if (hit_msk) rd_mux = mask_r;
        else rd_mux = 8'h00;
    end

    // ------------------------------------------------------------------
    // Hardware set terms
    // ------------------------------------------------------------------
    function automatic logic capcmp_hit(input capcmp_mode_type m, input capcmp_event_type e);
        case (m)
            CAPCMP_CAPTURE: capcmp_hit = e.capture;
            CAPCMP_COMPARE: capcmp_hit = e.compare_match;
            CAPCMP_PWM:     capcmp_hit = e.trailing_edge;
            default:        capcmp_hit = 1'b0;
        endcase
    endfunction : capcmp_hit

    logic [7:0] set6, set7;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_capcmp
            assign set6[gi] = capcmp_hit(capcmp_mode_select[gi], capcmp_event[gi]);
        end
    endgenerate
    assign set6[7:2] = 6'h00;
    assign set7 = {2'b00, nvm_done, nco_rollover, 3'b000, cwg_shutdown};

    // Set wins over a software clear in the same cycle
    wire [7:0] flags6_nxt = ((wr_en & hit_f6) ? wbyte : flags6_r) & FLAGS6_MASK | set6;
    wire [7:0] flags7_nxt = ((wr_en & hit_f7) ? wbyte : flags7_r) & FLAGS7_MASK | set7;

    // ------------------------------------------------------------------
    // Pending and request
    // ------------------------------------------------------------------
    wire pend_any = |(flags6_r & enable6_r) | |(flags7_r & enable7_r);
    wire cpu_req  = pend_any & global_r[GIE_BIT] & global_r[PERIPHERAL_INTERRUPT_ENABLE_BIT];

    // ------------------------------------------------------------------
    // Throttle control
    // ------------------------------------------------------------------
    wire       ten    = throttle_r[TEN_BIT];
    wire [2:0] ratio  = throttle_r[RATIO_LSB +: 3];
    // Last idle count in the period: N - 1 with N = 2^(code+1)
    wire [7:0] cnt_top = 8'((9'h002 << ratio) - 9'h001);
    wire       cnt_wrap = (doze_cnt_r >= cnt_top);

    always_comb begin
        throttle_nxt = throttle_r;
        if (wr_en & hit_thr) begin
            throttle_nxt = wbyte & THROTTLE_MASK;
        end
        if (core_event.isr_entry) begin
            throttle_nxt[TOE_BIT] = ten;
            if (ten & throttle_r[ROI_BIT]) begin
                throttle_nxt[TEN_BIT] = 1'b0;
            end
        end else if (core_event.isr_return) begin
            throttle_nxt[TEN_BIT] = throttle_nxt[TOE_BIT];
        end
    end

    wire [7:0] evt_set    = {5'h00, cpu_req & ~pending_d_r, core_event.isr_return,
                             core_event.isr_entry};
    wire [7:0] status_nxt = (status_r & ~((wr_en & hit_st) ? wbyte : 8'h00) | evt_set)
                            & STATUS_MASK;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_r   <= CTRL_RESET;
            flags6_r   <= FLAGS_RESET;
            flags7_r   <= FLAGS_RESET;
            enable6_r  <= CTRL_RESET;
            enable7_r  <= CTRL_RESET;
            throttle_r <= THROTTLE_RESET;
            status_r   <= FLAGS_RESET;
            mask_r     <= CTRL_RESET;
        end else begin
            if (wr_en & hit_glb) global_r <= wbyte & GLOBAL_MASK;
            if (wr_en & hit_e6) enable6_r <= wbyte & FLAGS6_MASK;
            if (wr_en & hit_e7) enable7_r <= wbyte & FLAGS7_MASK;
            if (wr_en & hit_msk) mask_r <= wbyte & STATUS_MASK;
            flags6_r   <= flags6_nxt;
            flags7_r   <= flags7_nxt;
            throttle_r <= throttle_nxt;
            status_r   <= status_nxt;
        end
    end

    // Phase counter: restarts whenever throttling is off so a new period opens cleanly
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            doze_cnt_r <= 8'h00;
        end else if (!ten || cnt_wrap) begin
            doze_cnt_r <= 8'h00;
        end else begin
            doze_cnt_r <= doze_cnt_r + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready               <= 1'b0;
            prdata               <= 32'h0000_0000;
            pslverr              <= 1'b0;
            cpu_irq_request      <= 1'b0;
            wake_request         <= 1'b0;
            cpu_clock_enable     <= 1'b1;
            periph_clock_enable  <= 1'b1;
            external_edge_select <= 1'b0;
            irq                  <= 1'b0;
            pending_d_r          <= 1'b0;
        end else begin
            // One wait state: answer comes the cycle after the access phase opens
            pready               <= psel & penable & ~pready;
            pslverr              <= psel & penable & ~pready & ~mapped;
            prdata               <= (rd_en & ~pready) ? {24'h000000, rd_mux} : 32'h0000_0000;
            cpu_irq_request      <= cpu_req;
            wake_request         <= pend_any;
            cpu_clock_enable     <= ~ten | (doze_cnt_r == 8'h00 && ten) & ~(!ten);
            periph_clock_enable  <= 1'b1;
            external_edge_select <= global_r[EDGE_BIT];
            irq                  <= |(status_r & mask_r);
            pending_d_r          <= cpu_req;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    cap_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        set6[0] |=> flags6_r[CAP1_BIT]) else $error("capture flag not set");
    nvm_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        nvm_done |=> flags7_r[NVM_BIT]) else $error("nvm flag not set");
    nco_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        nco_rollover |=> flags7_r[NCO_BIT]) else $error("nco flag not set");
    wave_flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        cwg_shutdown ##1 !(wr_en & hit_f7) |=> flags7_r[WAVE_BIT])
        else $error("shutdown flag lost");
    unimpl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (flags6_r & ~FLAGS6_MASK) == 8'h00 && (enable7_r & ~FLAGS7_MASK) == 8'h00)
        else $error("unimplemented bit set");
    doze_ratio_a: assert property (@(posedge pclk) disable iff (!presetn)
        ten && ratio == 3'h1 && doze_cnt_r == 8'h00 && !core_event.isr_entry
        && !(wr_en & hit_thr) |=> doze_cnt_r == 8'h01) else $error("ratio count wrong");
    entry_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_event.isr_entry |=> throttle_r[TOE_BIT] == $past(ten)) else $error("on-exit copy");
    recover_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_event.isr_entry && ten && throttle_r[ROI_BIT] |=> !ten) else $error("no recover");
    return_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_event.isr_return && !core_event.isr_entry && !(wr_en & hit_thr)
        |=> ten == throttle_r[TOE_BIT])
        else $error("return enable wrong");
    request_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_irq_request |-> $past(global_r[GIE_BIT])) else $error("request without global");

    // ------------------------------------------------------------------
    // Flag checks
    // ------------------------------------------------------------------
    cap2_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        set6[1] |=> flags6_r[CAP2_BIT])
        else $error("second capture flag not set");
    cap_flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        flags6_r[CAP1_BIT] && !(wr_en & hit_f6) |=> flags6_r[CAP1_BIT])
        else $error("capture flag dropped");
    cap2_flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        flags6_r[CAP2_BIT] && !(wr_en & hit_f6) |=> flags6_r[CAP2_BIT])
        else $error("second capture flag dropped");
    wave_flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
        cwg_shutdown |=> flags7_r[WAVE_BIT])
        else $error("shutdown flag not set");
    wave_flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_f7 && !wbyte[WAVE_BIT] && !cwg_shutdown |=> !flags7_r[WAVE_BIT])
        else $error("shutdown flag not cleared");
    nvm_flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        flags7_r[NVM_BIT] && !(wr_en & hit_f7) |=> flags7_r[NVM_BIT])
        else $error("nvm flag dropped");
    nco_flag_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        flags7_r[NCO_BIT] && !(wr_en & hit_f7) |=> flags7_r[NCO_BIT])
        else $error("nco flag dropped");
    flag6_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_f6 && set6 == 8'h00 |=> flags6_r == ($past(wbyte) & FLAGS6_MASK))
        else $error("flag bank 6 write lost");
    flag7_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_f7 && set7 == 8'h00 |=> flags7_r == ($past(wbyte) & FLAGS7_MASK))
        else $error("flag bank 7 write lost");
    ctrl_unimpl_a: assert property (@(posedge pclk) disable iff (!presetn)
        (enable6_r & ~FLAGS6_MASK) == 8'h00 && (flags7_r & ~FLAGS7_MASK) == 8'h00)
        else $error("unimplemented bit set");
    read_upper_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read bits set");

    // ------------------------------------------------------------------
    // Request checks
    // ------------------------------------------------------------------
    wake_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        wake_request == $past(pend_any))
        else $error("wake level wrong");
    request_peripheral_interrupt_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
        cpu_irq_request |-> $past(global_r[PERIPHERAL_INTERRUPT_ENABLE_BIT]) && $past(pend_any))
        else $error("request without peripheral enable");
    edge_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
        external_edge_select == $past(global_r[EDGE_BIT]))
        else $error("edge select copy wrong");
    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq == $past(|(status_r & mask_r)))
        else $error("irq level wrong");
    entry_status_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_event.isr_entry |=> status_r[0])
        else $error("entry status not set");
    return_status_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_event.isr_return |=> status_r[1])
        else $error("return status not set");
    status_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && hit_st && wbyte[1] && !core_event.isr_return |=> !status_r[1])
        else $error("status not cleared");

    // ------------------------------------------------------------------
    // Throttle checks
    // ------------------------------------------------------------------
    full_speed_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ten |=> cpu_clock_enable)
        else $error("not full speed");
    doze_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
        ten && doze_cnt_r == 8'h00 |=> cpu_clock_enable)
        else $error("execution slot missing");
    doze_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        ten && doze_cnt_r != 8'h00 |=> !cpu_clock_enable)
        else $error("idle slot executed");
    ratio4_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        ten && ratio == 3'h1 && doze_cnt_r == 8'h03 |=> doze_cnt_r == 8'h00)
        else $error("one in four period wrong");
    ratio32_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
        ten && ratio == 3'h4 && doze_cnt_r == 8'h1f |=> doze_cnt_r == 8'h00)
        else $error("one in thirty-two period wrong");
    ratio32_run_a: assert property (@(posedge pclk) disable iff (!presetn)
        ten && ratio == 3'h4 && doze_cnt_r < 8'h1f |=> doze_cnt_r == $past(doze_cnt_r) + 8'h01)
        else $error("phase count skipped");
    doze_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_event.isr_entry && ten && !throttle_r[ROI_BIT] && !(wr_en & hit_thr) |=> ten)
        else $error("throttle dropped in routine");
    idle_entry_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_event.isr_entry && !ten && !(wr_en & hit_thr) |=> !ten && !throttle_r[TOE_BIT])
        else $error("on-exit copy of clear enable");
    roi_speed_a: assert property (@(posedge pclk) disable iff (!presetn)
        core_event.isr_entry && ten && throttle_r[ROI_BIT] |=> ##1 cpu_clock_enable)
        else $error("routine not at full speed");

    // ------------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------------
    pready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held too long");
    answer_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready)
        else $error("answer late");
    slverr_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without ready");

endmodule : irq_doze

// *** tb/core_model.sv ***
// Behavioural CPU core that enters and leaves the service routine
`timescale 1ns/1ns
module core_model
    import irq_doze_pkg::*;
(
    input  wire logic     pclk,
    input  wire logic     presetn,
    input  wire logic     cpu_irq_request,
    input  wire logic     accept,
    input  wire logic     leave,
    output core_event_type core_event,
    output logic          in_service
);
    // One entry per routine; entry is held off while in_service is set, so nesting is never seen
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_event <= '0;
            in_service <= 1'b0;
        end else begin
            core_event.isr_entry  <= accept && cpu_irq_request && !in_service
                                     && !core_event.isr_entry;
            core_event.isr_return <= leave && in_service;
            if (core_event.isr_entry) in_service <= 1'b1;
            if (core_event.isr_return) in_service <= 1'b0;
        end
    end
endmodule : core_model

// *** tb/interrupt_flags_and_doze_control_bench.sv ***
// Self-checking bench for the interrupt flag bank and throttle block
`timescale 1ns/1ns
module interrupt_flags_and_doze_control_bench
    import irq_doze_pkg::*;
;
    logic             pclk, presetn, psel, penable, pwrite, pready, pslverr, err_seen;
    logic             nvm_done, nco_rollover, cwg_shutdown, cpu_irq_request, wake_request;
    logic             cpu_clock_enable, periph_clock_enable, external_edge_select, irq;
    logic             accept, leave, in_service;
    logic [7:0]       paddr;
    logic [31:0]      pwdata, prdata, r;
    capcmp_mode_type  mode [2];
    capcmp_event_type ev [2];
    core_event_type   core_event;
    int               err_total, checks, p;
    logic [7:0]       offs [7] = '{OFF_FLAGS6, OFF_FLAGS7, OFF_ENABLE6, OFF_ENABLE7,
                                   OFF_GLOBAL, OFF_THROTTLE, OFF_MASK};
    logic [7:0]       imp [7]  = '{8'h03, 8'h31, 8'h03, 8'h31, 8'hc1, 8'h77, 8'h07};
    logic [7:0]       exp7 [3] = '{8'h20, 8'h10, 8'h01};

    // ------------------------------------------------------------------
    // Design and core model
    // ------------------------------------------------------------------
    irq_doze u_irq_doze (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .capcmp_mode_select(mode), .capcmp_event(ev), .nvm_done(nvm_done),
        .nco_rollover(nco_rollover), .cwg_shutdown(cwg_shutdown), .core_event(core_event),
        .cpu_irq_request(cpu_irq_request), .wake_request(wake_request),
        .cpu_clock_enable(cpu_clock_enable), .periph_clock_enable(periph_clock_enable),
        .external_edge_select(external_edge_select), .irq(irq)
    );
    core_model u_core_model (
        .pclk(pclk), .presetn(presetn), .cpu_irq_request(cpu_irq_request), .accept(accept),
        .leave(leave), .core_event(core_event), .in_service(in_service)
    );

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Entered just after a rising edge; the idle cycle after release avoids double drives
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (pready !== 1'b1) err_total++;
        r = prdata;
        err_seen = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 8'h00);
        check(r, e);
    endtask : rc

    task automatic fire(input logic [2:0] k);
        {nvm_done, nco_rollover, cwg_shutdown} <= k;
        @(posedge pclk);
        {nvm_done, nco_rollover, cwg_shutdown} <= 3'b000;
        @(posedge pclk);
    endtask : fire

    // Cycles from one execution slot to the next; bounded so a stuck enable cannot hang
    task automatic period(output int q);
        q = 0;
        do begin
            @(posedge pclk);
            q++;
        end while (cpu_clock_enable !== 1'b1 && q < 600);
    endtask : period

    task automatic summarize();
        $display("checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial begin
        #400000;
        err_total++;
        summarize();
    end

    initial begin
        {presetn, psel, penable, pwrite, nvm_done, nco_rollover, cwg_shutdown} = '0;
        {accept, leave, paddr, pwdata} = '0;
        mode = '{CAPCMP_CAPTURE, CAPCMP_CAPTURE};
        ev = '{default: '0};
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 32; a += 4) rc(8'(a), 32'h0);
        rc(8'h20, 32'h0);
        check(err_seen, 1'b1);
        foreach (offs[i]) begin
            apb(1'b1, offs[i], 8'hff);
            rc(offs[i], {24'h000000, imp[i]});
            apb(1'b1, offs[i], 8'h00);
            rc(offs[i], 32'h0);
        end
        apb(1'b1, OFF_GLOBAL, 8'h01);
        check(external_edge_select, 1'b1);
        for (int u = 0; u < 2; u++) begin
            for (int m = 0; m < 3; m++) begin
                mode[u] <= capcmp_mode_type'(m);
                ev[u] <= capcmp_event_type'(3'b111 ^ (3'b100 >> m));
                @(posedge pclk);
                ev[u] <= '0;
                rc(OFF_FLAGS6, 32'h0);
                ev[u] <= capcmp_event_type'(3'b100 >> m);
                @(posedge pclk);
                ev[u] <= '0;
                rc(OFF_FLAGS6, 32'h1 << u);
                apb(1'b1, OFF_FLAGS6, 8'h00);
            end
        end
        for (int k = 0; k < 3; k++) begin
            fire(3'b100 >> k);
            rc(OFF_FLAGS7, {24'h000000, exp7[k]});
            apb(1'b1, OFF_FLAGS7, 8'h00);
            rc(OFF_FLAGS7, 32'h0);
        end
        apb(1'b1, OFF_ENABLE7, 8'h20);
        apb(1'b1, OFF_MASK, 8'h07);
        apb(1'b1, OFF_GLOBAL, 8'h00);
        fire(3'b100);
        repeat (2) @(posedge pclk);
        check(wake_request, 1'b1);
        check(cpu_irq_request, 1'b0);
        apb(1'b1, OFF_GLOBAL, 8'h80);
        check(cpu_irq_request, 1'b0);
        apb(1'b1, OFF_GLOBAL, 8'hc0);
        check(cpu_irq_request, 1'b1);
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, OFF_THROTTLE, 8'h40 | 8'(c));
            period(p);
            period(p);
            check(p, 2 << c);
            check(periph_clock_enable, 1'b1);
        end
        for (int recover_on_interrupt = 1; recover_on_interrupt >= 0; recover_on_interrupt--) begin
            apb(1'b1, OFF_THROTTLE, 8'h41 | 8'(recover_on_interrupt << 5));
            fire(3'b100);
            accept <= 1'b1;
            p = 0;
            while (in_service !== 1'b1 && p < 20) begin
                @(posedge pclk);
                p++;
            end
            accept <= 1'b0;
            apb(1'b1, OFF_FLAGS7, 8'h00);
            apb(1'b0, OFF_THROTTLE, 8'h00);
            check(r & 32'h50, (recover_on_interrupt == 1) ? 32'h10 : 32'h50);
            if (recover_on_interrupt == 1) begin
                repeat (8) begin
                    @(posedge pclk);
                    check(cpu_clock_enable, 1'b1);
                end
            end else begin
                period(p);
                period(p);
                check(p, 32'd4);
                apb(1'b1, OFF_THROTTLE, 8'h41);
            end
            leave <= 1'b1;
            @(posedge pclk);
            leave <= 1'b0;
            repeat (2) @(posedge pclk);
            apb(1'b0, OFF_THROTTLE, 8'h00);
            check(r & 32'h40, (recover_on_interrupt == 1) ? 32'h40 : 32'h0);
        end
        apb(1'b1, OFF_THROTTLE, 8'h00);
        check(irq, 1'b1);
        apb(1'b1, OFF_MASK, 8'h00);
        check(irq, 1'b0);
        apb(1'b1, OFF_MASK, 8'h07);
        apb(1'b1, OFF_STATUS, 8'h07);
        rc(OFF_STATUS, 32'h0);
        check(irq, 1'b0);
        fire(3'b010);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(OFF_FLAGS7, 32'h0);
        summarize();
    end
endmodule : interrupt_flags_and_doze_control_bench
